/* File: core/frac_cfg_pkg.sv */
// constants and types shared by the fractional divider configuration block
package frac_cfg_pkg;
   // =====================================================================
   // serial frame layout
   localparam int            ADDR_W     = 7;
   localparam int            DATA_W     = 16;
   localparam int            CNT_W      = 5;
   localparam logic [4:0]    HDR_LAST   = 5'h07;
   localparam logic [4:0]    DATA_LAST  = 5'h0f;
   localparam int            HDR_RW_BIT = 7;
   localparam int            PIN_SCK    = 0;
   localparam int            PIN_CS     = 1;
   localparam int            PIN_SDI    = 2;
   // sdi low, chip select high, sck low while idle
   localparam logic [2:0]    SYNC_RST   = 3'h2;
   // =====================================================================
   // register offsets
   localparam logic [6:0]    ADDR_INT     = 7'h24;
   localparam logic [6:0]    ADDR_DEN_HI  = 7'h26;
   localparam logic [6:0]    ADDR_DEN_LO  = 7'h27;
   localparam logic [6:0]    ADDR_SEED_HI = 7'h28;
   localparam logic [6:0]    ADDR_SEED_LO = 7'h29;
   localparam logic [6:0]    ADDR_NUM_HI  = 7'h2a;
   localparam logic [6:0]    ADDR_NUM_LO  = 7'h2b;
   localparam logic [6:0]    ADDR_CTRL    = 7'h2c;
   // =====================================================================
   // reset values and control fields
   localparam logic [15:0]   RST_INT      = 16'h0064;
   localparam logic [15:0]   RST_DEN_LO   = 16'h2710;
   localparam logic [15:0]   RST_ZERO     = 16'h0000;
   localparam logic [15:0]   RST_CTRL     = 16'h00a2;
   localparam logic [15:0]   CTRL_RW_MASK = 16'h00a7;
   localparam int            CTRL_OUTA    = 7;
   localparam int            CTRL_MOD_EN  = 5;
   localparam int            CTRL_ORDER   = 0;
   localparam int            ORDER_W      = 3;
   localparam logic [2:0]    MAX_ORDER    = 3'h3;
   localparam int            MOD_STAGES   = 3;
   localparam int            NDIV_W       = 18;
   // =====================================================================
   // serial port states
   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_HDR  = 2'b01,
      SPI_DATA = 2'b10,
      SPI_DONE = 2'b11
   } spi_state_t;
endpackage : frac_cfg_pkg

/* File: core/mod_if.sv */
// carrier between the register bank and the modulator
`timescale 1ns/1ps
`default_nettype none
interface mod_if;
   import frac_cfg_pkg::*;
   logic [15:0]        int_part;
   logic [31:0]        num;
   logic [31:0]        den;
   logic [31:0]        seed;
   logic [ORDER_W-1:0] order;
   logic               enable;
   logic               restart;
   logic               kick;
   logic               tick;
   logic [NDIV_W-1:0]  n_div;
   modport ctrl (output int_part, num, den, seed, order, enable, restart, kick, tick,
                 input n_div);
   modport mod  (input int_part, num, den, seed, order, enable, restart, kick, tick,
                 output n_div);
endinterface : mod_if
`default_nettype wire

/* File: core/mash_sequencer.sv */
// multi-stage sigma-delta sequencer of the feedback divide value
`timescale 1ns/1ps
`default_nettype none
module mash_sequencer (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // settings and divide value
   mod_if.mod        m
);
   import frac_cfg_pkg::*;
   // =====================================================================
   // accumulator chain
   logic [31:0]            acc_reg  [MOD_STAGES];
   logic [31:0]            acc_next [MOD_STAGES];
   logic [31:0]            new_acc  [MOD_STAGES];
   logic [MOD_STAGES-1:0]  cd1_reg, cd1_next, cd2_reg, cd2_next, carry;
   logic [NDIV_W-1:0]      n_div_reg, n_div_next;
   logic [32:0]            sum;
   logic [31:0]            in_v;
   logic [2:0]             eff;
   logic [4:0]             off;
   logic                   active;

   always_comb
   begin
      eff    = (m.order > MAX_ORDER) ? MAX_ORDER : m.order;
      active = m.enable && (eff != 3'h0);
      carry  = '0;
      in_v   = m.num;
      for (int i = 0; i < MOD_STAGES; i++)
      begin
         sum = {1'b0, acc_reg[i]} + {1'b0, in_v};
         if (sum >= {1'b0, m.den})
         begin
            sum      = sum - {1'b0, m.den};
            carry[i] = (3'(i) < eff);
         end
         new_acc[i] = sum[31:0];
         in_v       = sum[31:0];
      end
      // later stages cancel the quantisation error of earlier ones
      off = {4'h0, carry[0]} + {4'h0, carry[1]} - {4'h0, cd1_reg[1]} + {4'h0, carry[2]}
          - {3'h0, cd1_reg[2], 1'b0} + {4'h0, cd2_reg[2]};
      acc_next   = acc_reg;
      cd1_next   = cd1_reg;
      cd2_next   = cd2_reg;
      n_div_next = n_div_reg;
      sum        = '0;
      if (m.restart)
      begin
         acc_next[0] = m.seed;
         for (int i = 1; i < MOD_STAGES; i++)
            acc_next[i] = '0;
         cd1_next = '0;
         cd2_next = '0;
      end
      else if (m.kick)
      begin
         // seed below the denominator keeps one subtraction enough
         sum = {1'b0, acc_reg[0]} + {1'b0, m.seed};
         if (sum >= {1'b0, m.den})
            sum = sum - {1'b0, m.den};
         acc_next[0] = sum[31:0];
      end
      else if (m.tick && active)
      begin
         acc_next   = new_acc;
         cd1_next   = carry;
         cd2_next   = cd1_reg;
         n_div_next = {2'h0, m.int_part} + {{(NDIV_W-5){off[4]}}, off};
      end
      if (!active)
         n_div_next = {2'h0, m.int_part};
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < MOD_STAGES; i++)
            acc_reg[i] <= '0;
         cd1_reg   <= '0;
         cd2_reg   <= '0;
         n_div_reg <= '0;
      end
      else
      begin
         acc_reg   <= acc_next;
         cd1_reg   <= cd1_next;
         cd2_reg   <= cd2_next;
         n_div_reg <= n_div_next;
      end
   end

   assign m.n_div = n_div_reg;

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_seed_load_acc: assert property (m.restart |=> acc_reg[0] == $past(m.seed))
      else $error("seed not loaded on restart");
   a_integer_mode_out: assert property (!active |=> n_div_reg == {2'h0, $past(m.int_part)})
      else $error("integer mode divide value wrong");
   a_first_order_step: assert property ((m.tick && m.enable && m.order == 3'h1 && !m.restart
      && !m.kick) |=> n_div_reg == {2'h0, $past(m.int_part)} + NDIV_W'($past(carry[0])))
      else $error("first order step wrong");
endmodule : mash_sequencer
`default_nettype wire

/* File: core/frac_divider_regs.sv */
// serial-programmed fractional divider configuration registers
`timescale 1ns/1ps
`default_nettype none
module frac_divider_regs (
   // clock and reset
   input  wire logic                             mclk,
   input  wire logic                             rst,
   // serial control port
   input  wire logic                             spi_sck,
   input  wire logic                             spi_cs_n,
   input  wire logic                             spi_sdi,
   output var  logic                             spi_sdo,
   output var  logic                             spi_sdo_oe_n,
   // feedback divider
   input  wire logic                             div_tick,
   output var  logic [frac_cfg_pkg::NDIV_W-1:0]  n_div_value,
   // analog controls
   output var  logic                             out_a_disable,
   output var  logic                             modulator_enable,
   output var  logic [frac_cfg_pkg::ORDER_W-1:0] modulator_order
);
   import frac_cfg_pkg::*;

   // =====================================================================
   // pin synchronisers
   logic [2:0]  s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next, filt_reg, filt_next;
   logic        sck_rise, sck_fall, cs_act, sdi_bit;

   always_comb
   begin
      s1_next   = {spi_sdi, spi_cs_n, spi_sck};
      s2_next   = s1_reg;
      s3_next   = s2_reg;
      // a level counts only once two stages agree, which rejects single glitches
      filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg   <= SYNC_RST;
         s2_reg   <= SYNC_RST;
         s3_reg   <= SYNC_RST;
         filt_reg <= SYNC_RST;
      end
      else
      begin
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         s3_reg   <= s3_next;
         filt_reg <= filt_next;
      end
   end

   assign sck_rise = filt_next[PIN_SCK] & ~filt_reg[PIN_SCK];
   assign sck_fall = ~filt_next[PIN_SCK] & filt_reg[PIN_SCK];
   assign cs_act   = ~filt_next[PIN_CS];
   assign sdi_bit  = filt_next[PIN_SDI];

   // =====================================================================
   // register bank state
   logic [15:0] int_reg, int_next, den_hi_reg, den_hi_next, den_lo_reg, den_lo_next;
   logic [15:0] seed_hi_reg, seed_hi_next, seed_lo_reg, seed_lo_next;
   logic [15:0] num_hi_reg, num_hi_next, num_lo_reg, num_lo_next, ctrl_reg, ctrl_next;
   logic        restart_reg, restart_next, kick_reg, kick_next;

   function automatic logic [15:0] read_word(input logic [6:0] a);
      case (a)
         ADDR_INT:     read_word = int_reg;
         ADDR_DEN_HI:  read_word = den_hi_reg;
         ADDR_DEN_LO:  read_word = den_lo_reg;
         ADDR_SEED_HI: read_word = seed_hi_reg;
         ADDR_SEED_LO: read_word = seed_lo_reg;
         ADDR_NUM_HI:  read_word = num_hi_reg;
         ADDR_NUM_LO:  read_word = num_lo_reg;
         ADDR_CTRL:    read_word = ctrl_reg & CTRL_RW_MASK;
         default:      read_word = RST_ZERO;
      endcase
   endfunction : read_word

   // =====================================================================
   // serial frame: read flag, 7-bit address, 16 data bits, msb first
   spi_state_t        state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   logic [15:0]       sh_reg, sh_next, out_reg, out_next, wr_data;
   logic [6:0]        addr_reg, addr_next;
   logic [7:0]        header;
   logic              rw_reg, rw_next, oe_n_reg, oe_n_next, wr_en;

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      out_next   = out_reg;
      addr_next  = addr_reg;
      rw_next    = rw_reg;
      oe_n_next  = oe_n_reg;
      wr_en      = 1'b0;
      wr_data    = {sh_reg[14:0], sdi_bit};
      header     = {sh_reg[6:0], sdi_bit};
      if (!cs_act)
      begin
         state_next = SPI_IDLE;
         cnt_next   = '0;
         oe_n_next  = 1'b1;
      end
      else
      begin
         case (state_reg)
            SPI_IDLE: state_next = SPI_HDR;
            SPI_HDR:
               if (sck_rise)
               begin
                  sh_next  = wr_data;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == HDR_LAST)
                  begin
                     rw_next    = header[HDR_RW_BIT];
                     addr_next  = header[6:0];
                     cnt_next   = '0;
                     state_next = SPI_DATA;
                     out_next   = read_word(header[6:0]);
                     oe_n_next  = ~header[HDR_RW_BIT];
                  end
               end
            SPI_DATA:
               if (sck_rise)
               begin
                  sh_next  = wr_data;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == DATA_LAST)
                  begin
                     state_next = SPI_DONE;
                     wr_en      = ~rw_reg;
                  end
               end
               // the falling edge right after the load must not shift
               else if (sck_fall && (cnt_reg != 5'h00))
                  out_next = {out_reg[14:0], 1'b0};
            SPI_DONE: oe_n_next = 1'b1;
            default:  state_next = SPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= SPI_IDLE;
         cnt_reg   <= '0;
         sh_reg    <= '0;
         out_reg   <= '0;
         addr_reg  <= '0;
         rw_reg    <= 1'b0;
         oe_n_reg  <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         out_reg   <= out_next;
         addr_reg  <= addr_next;
         rw_reg    <= rw_next;
         oe_n_reg  <= oe_n_next;
      end
   end

   assign spi_sdo      = out_reg[15];
   assign spi_sdo_oe_n = oe_n_reg;

   // =====================================================================
   // register writes
   always_comb
   begin
      int_next     = int_reg;
      den_hi_next  = den_hi_reg;
      den_lo_next  = den_lo_reg;
      seed_hi_next = seed_hi_reg;
      seed_lo_next = seed_lo_reg;
      num_hi_next  = num_hi_reg;
      num_lo_next  = num_lo_reg;
      ctrl_next    = ctrl_reg;
      restart_next = 1'b0;
      kick_next    = 1'b0;
      if (wr_en)
      begin
         case (addr_reg)
            ADDR_INT:     int_next     = wr_data;
            ADDR_DEN_HI:  den_hi_next  = wr_data;
            ADDR_DEN_LO:  den_lo_next  = wr_data;
            ADDR_SEED_HI: seed_hi_next = wr_data;
            ADDR_SEED_LO:
            begin
               seed_lo_next = wr_data;
               kick_next    = 1'b1;
            end
            ADDR_NUM_HI:  num_hi_next  = wr_data;
            ADDR_NUM_LO:  num_lo_next  = wr_data;
            ADDR_CTRL:
            begin
               ctrl_next    = wr_data & CTRL_RW_MASK;
               restart_next = ~ctrl_reg[CTRL_MOD_EN] & wr_data[CTRL_MOD_EN];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         int_reg     <= RST_INT;
         den_hi_reg  <= RST_ZERO;
         den_lo_reg  <= RST_DEN_LO;
         seed_hi_reg <= RST_ZERO;
         seed_lo_reg <= RST_ZERO;
         num_hi_reg  <= RST_ZERO;
         num_lo_reg  <= RST_ZERO;
         ctrl_reg    <= RST_CTRL;
         restart_reg <= 1'b0;
         kick_reg    <= 1'b0;
      end
      else
      begin
         int_reg     <= int_next;
         den_hi_reg  <= den_hi_next;
         den_lo_reg  <= den_lo_next;
         seed_hi_reg <= seed_hi_next;
         seed_lo_reg <= seed_lo_next;
         num_hi_reg  <= num_hi_next;
         num_lo_reg  <= num_lo_next;
         ctrl_reg    <= ctrl_next;
         restart_reg <= restart_next;
         kick_reg    <= kick_next;
      end
   end

   // =====================================================================
   // modulator
   mod_if mif ();

   assign mif.int_part = int_reg;
   assign mif.num      = {num_hi_reg, num_lo_reg};
   assign mif.den      = {den_hi_reg, den_lo_reg};
   assign mif.seed     = {seed_hi_reg, seed_lo_reg};
   assign mif.order    = ctrl_reg[CTRL_ORDER +: ORDER_W];
   assign mif.enable   = ctrl_reg[CTRL_MOD_EN];
   assign mif.restart  = restart_reg;
   assign mif.kick     = kick_reg;
   assign mif.tick     = div_tick;

   mash_sequencer u_seq (
      .mclk (mclk),
      .rst  (rst),
      .m    (mif.mod)
   );

   assign n_div_value      = mif.n_div;
   assign out_a_disable    = ctrl_reg[CTRL_OUTA];
   assign modulator_enable = ctrl_reg[CTRL_MOD_EN];
   assign modulator_order  = ctrl_reg[CTRL_ORDER +: ORDER_W];

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_seed_write;
      wr_en && addr_reg == ADDR_SEED_LO;
   endsequence
   sequence s_kick_pulse;
      kick_reg ##1 !kick_reg;
   endsequence

   a_den_hi_store: assert property (wr_en && addr_reg == ADDR_DEN_HI
      |=> den_hi_reg == $past(wr_data)) else $error("denominator upper half not stored");
   a_den_lo_store: assert property (wr_en && addr_reg == ADDR_DEN_LO
      |=> den_lo_reg == $past(wr_data)) else $error("denominator lower half not stored");
   a_num_hi_store: assert property (wr_en && addr_reg == ADDR_NUM_HI
      |=> num_hi_reg == $past(wr_data)) else $error("numerator upper half not stored");
   a_num_lo_store: assert property (wr_en && addr_reg == ADDR_NUM_LO
      |=> num_lo_reg == $past(wr_data)) else $error("numerator lower half not stored");
   a_seed_hi_store: assert property (wr_en && addr_reg == ADDR_SEED_HI
      |=> seed_hi_reg == $past(wr_data)) else $error("seed upper half not stored");
   a_seed_phase_kick: assert property (s_seed_write |=> s_kick_pulse)
      else $error("seed write gave no phase kick");
   a_outa_gate: assert property (wr_en && addr_reg == ADDR_CTRL
      |=> out_a_disable == $past(wr_data[CTRL_OUTA])) else $error("output A gate not updated");
   a_restart_edge: assert property (wr_en && addr_reg == ADDR_CTRL
      |=> restart_reg == ($past(wr_data[CTRL_MOD_EN]) && !$past(ctrl_reg[CTRL_MOD_EN])))
      else $error("restart pulse wrong");
   a_order_field: assert property (wr_en && addr_reg == ADDR_CTRL
      |=> modulator_order == $past(wr_data[2:0])) else $error("order field not updated");
   a_ctrl_reserved: assert property ((ctrl_reg & ~CTRL_RW_MASK) == RST_ZERO)
      else $error("reserved control bits set");
   a_int_store: assert property (wr_en && addr_reg == ADDR_INT
      |=> int_reg == $past(wr_data)) else $error("integer part not stored");
endmodule : frac_divider_regs
`default_nettype wire

/* File: dv/spi_host_model.sv */
// serial host model that programs the configuration registers in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // clock
   input  wire logic        mclk,
   // command from the bench
   input  wire logic        start,
   input  wire logic        rd,
   input  wire logic [6:0]  addr,
   input  wire logic [15:0] wdata,
   output var  logic        busy,
   output var  logic [15:0] rdata,
   // serial pins
   output var  logic        spi_sck,
   output var  logic        spi_cs_n,
   output var  logic        spi_sdi,
   input  wire logic        spi_sdo
);
   // half period well above the 5-cycle floor of the pin synchroniser
   localparam int HALF = 8;
   // =====================================================================
   // frame engine
   task automatic pause(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         spi_sdi <= ~spi_sdi;
      end
   endtask : pause

   task automatic frame();
      logic [23:0] sh;
      sh = {rd, addr, wdata};
      busy <= 1'b1;
      spi_cs_n <= 1'b0;
      pause(HALF);
      for (int i = 23; i >= 0; i--)
      begin
         spi_sdi <= sh[i];
         repeat (HALF) @(posedge mclk);
         spi_sck <= 1'b1;
         if (i < 16)
            rdata[i] <= spi_sdo;
         repeat (HALF) @(posedge mclk);
         spi_sck <= 1'b0;
      end
      pause(HALF);
      spi_cs_n <= 1'b1;
      pause(HALF);
      busy <= 1'b0;
   endtask : frame

   initial
   begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      busy = 1'b0;
      rdata = 16'h0000;
      forever
      begin
         @(posedge mclk);
         // an idle data line never keeps its last bit
         if (start !== 1'b1)
            spi_sdi <= ~spi_sdi;
         else
            frame();
      end
   end
endmodule : spi_host_model
`default_nettype wire

/* File: dv/fractional_divider_config_regs_tb.sv */
// random and directed bench of the fractional divider configuration registers
`timescale 1ns/1ps
`default_nettype none
module fractional_divider_config_regs_tb;
   import frac_cfg_pkg::*;
   // =====================================================================
   // pins and bench state
   logic              mclk = 1'b0;
   logic              rst = 1'b1;
   logic              div_tick = 1'b0;
   logic              start = 1'b0;
   logic              rd_cmd = 1'b0;
   logic [6:0]        addr_cmd = 7'h00;
   logic [15:0]       wdata_cmd = 16'h0000;
   logic              busy, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
   logic [15:0]       rdata;
   logic [NDIV_W-1:0] n_div_value;
   logic              out_a_disable, modulator_enable;
   logic [2:0]        modulator_order;
   logic [31:0]       x = 32'h7d33;
   int                mismatches = 0;
   int                total_checks = 0;
   longint            ip, den, num, acc, sum;
   logic [6:0]        map_a [8] = '{ADDR_INT, ADDR_DEN_HI, ADDR_DEN_LO, ADDR_SEED_HI,
                                    ADDR_SEED_LO, ADDR_NUM_HI, ADDR_NUM_LO, ADDR_CTRL};
   logic [15:0]       shadow [8] = '{RST_INT, RST_ZERO, RST_DEN_LO, RST_ZERO,
                                     RST_ZERO, RST_ZERO, RST_ZERO, RST_CTRL};
   always #10 mclk = ~mclk;
   // =====================================================================
   // design and host
   frac_divider_regs i_dut (.mclk(mclk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .div_tick(div_tick),
      .n_div_value(n_div_value), .out_a_disable(out_a_disable),
      .modulator_enable(modulator_enable), .modulator_order(modulator_order));
   spi_host_model i_host (.mclk(mclk), .start(start), .rd(rd_cmd), .addr(addr_cmd),
      .wdata(wdata_cmd), .busy(busy), .rdata(rdata), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo ^ spi_sdo_oe_n)); // released line reads inverted
   // =====================================================================
   // helpers
   function logic [31:0] xs();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] d);
      int n;
      n = 0;
      rd_cmd <= r;
      addr_cmd <= a;
      wdata_cmd <= d;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (busy === 1'b1 && n < 2000);
      if (n >= 2000)
      begin
         mismatches++;
         $display("ERROR t=%0t host stuck got=%h exp=%h", $time, n, 2000);
      end
   endtask : xfer

   task automatic readall();
      for (int i = 0; i < 8; i++)
      begin
         xfer(1'b1, map_a[i], 16'h0000);
         chk(rdata, shadow[i]);
      end
   endtask : readall

   // one divider cycle per call step; order 1 is exact, order 0 is the integer part
   task automatic ticks(input longint k, input logic [2:0] ord);
      for (longint i = 0; i < k; i++)
      begin
         div_tick <= 1'b1;
         @(posedge mclk);
         div_tick <= 1'b0;
         repeat (3) @(posedge mclk);
         sum += n_div_value;
         acc += num;
         if (ord == 3'h1)
            chk(n_div_value, NDIV_W'(ip + (acc >= den)));
         if (ord == 3'h0)
            chk(n_div_value, NDIV_W'(ip));
         if (acc >= den)
            acc -= den;
      end
   endtask : ticks

   task automatic mod_run(input logic [2:0] ord);
      longint d;
      ip = 100 + xs() % 1000;
      den = 3 + xs() % 40;
      num = xs() % den;
      acc = xs() % den;
      xfer(1'b0, ADDR_CTRL, 16'h0080 | 16'(ord));
      xfer(1'b0, ADDR_INT, 16'(ip));
      xfer(1'b0, ADDR_DEN_HI, 16'h0000);
      xfer(1'b0, ADDR_DEN_LO, 16'(den));
      xfer(1'b0, ADDR_NUM_HI, 16'h0000);
      xfer(1'b0, ADDR_NUM_LO, 16'(num));
      xfer(1'b0, ADDR_SEED_HI, 16'h0000);
      xfer(1'b0, ADDR_SEED_LO, 16'(acc));
      chk(n_div_value, NDIV_W'(ip));
      chk(modulator_enable, 1'b0);
      xfer(1'b0, ADDR_CTRL, 16'h00a0 | 16'(ord));
      sum = 0;
      ticks(4 * den, ord);
      d = sum - 4 * den * ip - 4 * num;
      if (ord != 3'h0)
         chk(d >= -4 && d <= 4, 1'b1);
      if (ord == 3'h1)
      begin
         d = xs() % den;
         xfer(1'b0, ADDR_SEED_LO, 16'(d));
         acc = (acc + d) % den;
         ticks(den, ord);
      end
      $display("test modulator order %0d done", ord);
   endtask : mod_run
   // =====================================================================
   // tests
   initial
   begin
      logic [15:0] v;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(out_a_disable, 1'b1);
      chk(modulator_enable, 1'b1);
      chk(modulator_order, 3'h2);
      readall();
      $display("test reset values done");
      xfer(1'b0, 7'h25, 16'hffff);
      xfer(1'b1, 7'h25, 16'h0000);
      chk(rdata, 16'h0000);
      readall();
      $display("test unmapped access done");
      for (int r = 0; r < 3; r++)
      begin
         for (int i = 0; i < 7; i++)
         begin
            shadow[i] = 16'(xs());
            if (i == 1)
               shadow[i] |= 16'h0002;
            if (i == 3)
               shadow[i] = shadow[1] >> 1;
            xfer(1'b0, map_a[i], shadow[i]);
         end
         v = 16'(xs()) | 16'h0020;
         shadow[7] = v & CTRL_RW_MASK;
         xfer(1'b0, ADDR_CTRL, v);
         chk(out_a_disable, v[7]);
         chk(modulator_order, v[2:0]);
         readall();
      end
      $display("test random read back done");
      // order 7 must behave as the highest supported order
      for (int o = 0; o < 5; o++)
         mod_run((o == 4) ? 3'h7 : 3'(o));
      tally_and_finish();
   end

   // hang guard, about twice the expected run
   initial
   begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
endmodule : fractional_divider_config_regs_tb
`default_nettype wire
